// *** rtl/mode0_rail_cfg.svh ***
`ifndef MODE0_RAIL_CFG_SVH
`define MODE0_RAIL_CFG_SVH

// Register offsets
`define ADDR_SYSBUCK_ONPIN   8'h23
`define ADDR_LDO_ENABLE     8'h24

// Field positions, register 23h
`define POS_RSVD            7
`define POS_ONPIN_CFG       6
`define POS_SYSBUCK_OFFSET  5
`define POS_SYSBUCK_CODE_HI 4
`define POS_SYSBUCK_CODE_LO 0

// Field positions, register 24h
`define POS_AON_CODE_HI     7
`define POS_AON_CODE_LO     4
`define POS_COREBUCK_EN     3
`define POS_SYSBUCK_EN      2
`define POS_AON_EN          1
`define POS_SYS_LDO_EN      0

// Reset values
`define RST_RSVD            1'h0
`define RST_ONPIN_CFG       1'h0
`define RST_SYSBUCK_OFFSET  1'h0
`define RST_SYSBUCK_CODE    5'h0C
`define RST_AON_CODE        4'h4
`define RST_ENABLES         4'hF

// Code ranges and voltage steps in millivolts
`define SYSBUCK_CODE_MAX    5'h18
`define AON_CODE_MAX        4'h8
`define SYSBUCK_BASE_MV     12'h5DC
`define SYSBUCK_OFFSET_MV   12'h4B0
`define AON_BASE_MV         12'h6A4
`define STEP_MV             12'h019

`endif

// *** rtl/mode0_rail_pkg.sv ***
package mode0_rail_pkg;

	// Operating mode settings
	typedef enum logic [1:0] {
		MODE_0 = 2'h0,
		MODE_1 = 2'h1,
		MODE_2 = 2'h2,
		MODE_3 = 2'h3
	} mode_type;

	// Source of mode requests
	typedef enum logic {
		SRC_REGISTER = 1'h0,
		SRC_PINS     = 1'h1
	} mode_source_type;

endpackage

// *** rtl/onpin_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mode0_rail_cfg.svh"

module onpin_mode_ctrl
	import mode0_rail_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       mode_source_pin_sel_m0,
	input  wire logic       mode_select_pin_a,
	input  wire logic       mode_select_pin_b,
	input  wire logic [1:0] reg_mode_bits,
	input  wire logic       onpin_fall,
	input  wire logic       onpin_cfg,
	output mode_type        active_mode
);

	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [1:0] pin_mode;
	logic [1:0] last_request;

	// Pin synchronisers, three stages each
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {sync_a[1:0], mode_select_pin_a};
			sync_b <= {sync_b[1:0], mode_select_pin_b};
		end
	end

	// Pin change taken once stages two and three agree
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_mode <= 2'h0;
		end else begin
			if (sync_a[1] == sync_a[2]) begin
				pin_mode[0] <= sync_a[2];
			end
			if (sync_b[1] == sync_b[2]) begin
				pin_mode[1] <= sync_b[2];
			end
		end
	end

	mode_source_type source;
	logic [1:0]      request;
	logic            request_changed;
	logic            return_to_m0;
	mode_type        next_active_mode;

	assign source = mode_source_type'(mode_source_pin_sel_m0);
	assign request_changed = (request != last_request);
	// R01: falling edge returns to mode 0
	// R02: config set keeps current mode
	assign return_to_m0 = onpin_fall && (onpin_cfg == 1'h0);

	// R14: only one source is heard
	always_comb begin
		unique case (source)
			SRC_PINS:     request = pin_mode;
			SRC_REGISTER: request = reg_mode_bits;
		endcase
	end

	// On-pin return outranks a new request
	assign next_active_mode = return_to_m0    ? MODE_0 :
	                          request_changed ? mode_type'(request) :
	                          active_mode;

	// Mode state and last seen request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			active_mode  <= MODE_0;
			last_request <= 2'h0;
		end else begin
			active_mode  <= next_active_mode;
			last_request <= request;
		end
	end

endmodule

`default_nettype wire

// *** rtl/mode0_rail_config_regs.sv ***
// What this block does
// R01: With the on-pin return select clear, a valid on-pin falling edge switches to mode 0.
// R02: With the on-pin return select set, an on-pin falling edge leaves the mode unchanged.
// R03: The system-buck offset bit adds 0 V when clear and 1.2 V when set, reset 0.
// R04: System-buck code 0..24 gives 1.500 V to 2.100 V in 25 mV steps, above 24 stays 2.1 V.
// R05: The system-buck code resets to 01100, that is 1.8 V.
// R06: Always-on LDO code 0..8 gives 1.700 V to 1.900 V in 25 mV steps, above 8 stays 1.9 V.
// R07: The always-on LDO code resets to 0100, that is 1.8 V.
// R08: Bit 3 of 24h enables the core buck in mode 0, reset 1.
// R09: Bit 2 of 24h enables the system buck in mode 0, reset 1.
// R10: Bit 1 of 24h enables the always-on LDO in mode 0, reset 1.
// R11: Bit 0 of 24h enables the system LDO in mode 0, reset 1.
// R12: The four enable defaults come from per-device nonvolatile trim bits.
// R13: Registers 23h and 24h are fully read/write, with bit 7 of 23h reserved, reset 0.
// R14: A selection bit picks either the mode pins or the register mode bits as mode source.
// R15: While mode 0 is active the rail controls follow the mode-0 fields.
// R16: The on-pin falling-edge input is an already qualified one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "mode0_rail_cfg.svh"

module mode0_rail_config_regs
	import mode0_rail_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [3:0]  rewritable_nv_trim,
	input  wire logic        mode_source_pin_sel_m0,
	input  wire logic        mode_select_pin_a,
	input  wire logic        mode_select_pin_b,
	input  wire logic [1:0]  reg_mode_bits,
	input  wire logic        onpin_fall,
	output mode_type         active_mode,
	output logic             mode0_active,
	output logic             corebuck_enable,
	output logic             sysbuck_enable,
	output logic             aon_ldo_enable,
	output logic             sys_ldo_enable,
	output logic [4:0]       sysbuck_code,
	output logic             sysbuck_offset,
	output logic [3:0]       aon_ldo_code,
	output logic [11:0]      sysbuck_mv,
	output logic [11:0]      aon_ldo_mv
);

	// Clamp a code to its top step
	function automatic logic [4:0] clamp_code(input logic [4:0] code,
	                                          input logic [4:0] top);
		clamp_code = (code > top) ? top : code;
	endfunction

	// Stored fields of 23h
	logic       rsvd_bit;
	logic       onpin_cfg;
	logic       sysbuck_offset_m0;
	logic [4:0] sysbuck_code_m0;

	// Stored fields of 24h
	logic [3:0] aon_ldo_code_m0;
	logic       corebuck_enable_m0;
	logic       sysbuck_enable_m0;
	logic       aon_ldo_enable_m0;
	logic       sys_ldo_enable_m0;

	// Trim load happens once, right after reset release
	logic       trim_pending;

	// Address decode
	logic       hit_sysbuck;
	logic       hit_ldo;
	logic       wr_sysbuck;
	logic       wr_ldo;
	assign hit_sysbuck = (reg_addr == `ADDR_SYSBUCK_ONPIN);
	assign hit_ldo     = (reg_addr == `ADDR_LDO_ENABLE);
	assign wr_sysbuck  = reg_wr && hit_sysbuck;
	assign wr_ldo      = reg_wr && hit_ldo;

	// Read images of both registers
	logic [7:0] image_sysbuck;
	logic [7:0] image_ldo;
	logic [7:0] next_rdata;
	assign image_sysbuck = {rsvd_bit, onpin_cfg, sysbuck_offset_m0, sysbuck_code_m0};
	assign image_ldo     = {aon_ldo_code_m0, corebuck_enable_m0, sysbuck_enable_m0,
	                        aon_ldo_enable_m0, sys_ldo_enable_m0};
	// R13: both registers read back, others read zero
	assign next_rdata = hit_sysbuck ? image_sysbuck :
	                    hit_ldo     ? image_ldo     :
	                    8'h00;

	// Register 23h storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rsvd_bit          <= `RST_RSVD;
			onpin_cfg         <= `RST_ONPIN_CFG;
			sysbuck_offset_m0 <= `RST_SYSBUCK_OFFSET;
			// R05: default code 1.8 V
			sysbuck_code_m0   <= `RST_SYSBUCK_CODE;
		// R13: full write including reserved bit
		end else if (wr_sysbuck) begin
			rsvd_bit          <= reg_wdata[`POS_RSVD];
			onpin_cfg         <= reg_wdata[`POS_ONPIN_CFG];
			sysbuck_offset_m0 <= reg_wdata[`POS_SYSBUCK_OFFSET];
			sysbuck_code_m0   <= reg_wdata[`POS_SYSBUCK_CODE_HI:`POS_SYSBUCK_CODE_LO];
		end
	end

	// Register 24h voltage code
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// R07: default code 1.8 V
			aon_ldo_code_m0 <= `RST_AON_CODE;
		end else if (wr_ldo) begin
			aon_ldo_code_m0 <= reg_wdata[`POS_AON_CODE_HI:`POS_AON_CODE_LO];
		end
	end

	// Enable defaults before trim is loaded
	logic [3:0] enable_vector;
	logic [3:0] next_enable_vector;
	// R12: trim replaces defaults after release
	// R08: core buck enable bit
	// R09: system buck enable bit
	// R10: always-on LDO enable bit
	// R11: system LDO enable bit
	assign next_enable_vector = wr_ldo       ? reg_wdata[`POS_COREBUCK_EN:`POS_SYS_LDO_EN] :
	                            trim_pending ? rewritable_nv_trim :
	                            enable_vector;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enable_vector <= `RST_ENABLES;
			trim_pending  <= 1'h1;
		end else begin
			enable_vector <= next_enable_vector;
			trim_pending  <= 1'h0;
		end
	end

	assign corebuck_enable_m0 = enable_vector[`POS_COREBUCK_EN];
	assign sysbuck_enable_m0  = enable_vector[`POS_SYSBUCK_EN];
	assign aon_ldo_enable_m0  = enable_vector[`POS_AON_EN];
	assign sys_ldo_enable_m0  = enable_vector[`POS_SYS_LDO_EN];

	// Read data register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// Mode tracking and on-pin return
	mode_type mode_now;
	// R16: pulse used as is, no filtering here
	onpin_mode_ctrl u_mode_ctrl (
		.ref_clk                (ref_clk),
		.rst                    (rst),
		.mode_source_pin_sel_m0 (mode_source_pin_sel_m0),
		.mode_select_pin_a      (mode_select_pin_a),
		.mode_select_pin_b      (mode_select_pin_b),
		.reg_mode_bits          (reg_mode_bits),
		.onpin_fall             (onpin_fall),
		.onpin_cfg              (onpin_cfg),
		.active_mode            (mode_now)
	);
	assign active_mode = mode_now;

	// Effective voltages in millivolts
	logic [4:0]  sys_step;
	logic [4:0]  aon_step;
	logic [11:0] next_sysbuck_mv;
	logic [11:0] next_aon_mv;
	// R04: system-buck codes above 24 clamp
	assign sys_step = clamp_code(sysbuck_code_m0, `SYSBUCK_CODE_MAX);
	// R06: LDO codes above 8 clamp
	assign aon_step = clamp_code({1'h0, aon_ldo_code_m0}, {1'h0, `AON_CODE_MAX});
	// R03: offset adds 1.2 V when set
	assign next_sysbuck_mv = `SYSBUCK_BASE_MV + 12'(sys_step * `STEP_MV) +
	                         (sysbuck_offset_m0 ? `SYSBUCK_OFFSET_MV : 12'h000);
	assign next_aon_mv = `AON_BASE_MV + 12'(aon_step * `STEP_MV);

	logic in_mode0;
	assign in_mode0 = (mode_now == MODE_0);

	// R15: rail controls follow mode 0 only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode0_active    <= 1'h0;
			corebuck_enable <= 1'h0;
			sysbuck_enable  <= 1'h0;
			aon_ldo_enable  <= 1'h0;
			sys_ldo_enable  <= 1'h0;
			sysbuck_code    <= 5'h00;
			sysbuck_offset  <= 1'h0;
			aon_ldo_code    <= 4'h0;
			sysbuck_mv      <= 12'h000;
			aon_ldo_mv      <= 12'h000;
		end else if (in_mode0) begin
			mode0_active    <= 1'h1;
			corebuck_enable <= corebuck_enable_m0;
			sysbuck_enable  <= sysbuck_enable_m0;
			aon_ldo_enable  <= aon_ldo_enable_m0;
			sys_ldo_enable  <= sys_ldo_enable_m0;
			sysbuck_code    <= sysbuck_code_m0;
			sysbuck_offset  <= sysbuck_offset_m0;
			aon_ldo_code    <= aon_ldo_code_m0;
			sysbuck_mv      <= next_sysbuck_mv;
			aon_ldo_mv      <= next_aon_mv;
		end else begin
			mode0_active    <= 1'h0;
		end
	end

endmodule

`default_nettype wire

// *** test/reg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port
module reg_host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		reg_wdata <= ~v; // Released data shows no stale value
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask
endmodule

`default_nettype wire

// *** test/rail_cfg_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mode0_rail_cfg.svh"

module rail_cfg_checker
	import mode0_rail_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        mode_source_pin_sel_m0,
	input wire logic [1:0]  reg_mode_bits,
	input wire logic        onpin_fall,
	input wire mode_type    active_mode,
	input wire logic        mode0_active,
	input wire logic        corebuck_enable,
	input wire logic        sysbuck_enable,
	input wire logic        aon_ldo_enable,
	input wire logic        sys_ldo_enable,
	input wire logic [4:0]  sysbuck_code,
	input wire logic        sysbuck_offset,
	input wire logic [3:0]  aon_ldo_code,
	input wire logic [11:0] sysbuck_mv,
	input wire logic [11:0] aon_ldo_mv
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic       ret_off;
	logic [5:0] wd_low;
	logic [7:0] rails;
	// Mirror of the on-pin return select
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			ret_off <= 1'h0;
		else if (reg_wr && reg_addr == `ADDR_SYSBUCK_ONPIN)
			ret_off <= reg_wdata[`POS_ONPIN_CFG];
	end
	assign wd_low = reg_wdata[5:0];
	assign rails = {aon_ldo_code, corebuck_enable, sysbuck_enable, aon_ldo_enable, sys_ldo_enable};

	rd_unmapped_a: assert property (
		reg_rd && reg_addr != 8'h23 && reg_addr != 8'h24 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	onpin_return_a: assert property (
		onpin_fall && !ret_off |=> active_mode == MODE_0) else $error("no return to mode 0");
	onpin_hold_a: assert property (
		onpin_fall && ret_off && !mode_source_pin_sel_m0 && $stable(reg_mode_bits)
		&& $stable(mode_source_pin_sel_m0) |=> $stable(active_mode))
		else $error("mode changed on ignored edge");
	mode0_flag_a: assert property (
		mode0_active == (!$past(rst) && $past(active_mode) == MODE_0))
		else $error("mode 0 flag wrong");
	sysbuck_mv_a: assert property (
		mode0_active |-> sysbuck_mv == 12'h5DC + (sysbuck_offset ? 12'h4B0 : 12'h000)
		+ 12'h019 * (sysbuck_code > 5'h18 ? 12'h018 : {7'h00, sysbuck_code}))
		else $error("system buck millivolts wrong");
	aon_mv_a: assert property (
		mode0_active |-> aon_ldo_mv == 12'h6A4
		+ 12'h019 * (aon_ldo_code > 4'h8 ? 12'h008 : {8'h00, aon_ldo_code}))
		else $error("always-on millivolts wrong");
	rail_hold_a: assert property (
		!mode0_active && !$past(mode0_active) |-> $stable(rails) && $stable(sysbuck_mv)
		&& $stable({sysbuck_offset, sysbuck_code})) else $error("rails moved outside mode 0");
	enable_write_a: assert property (
		(reg_wr && reg_addr == 8'h24 && active_mode == MODE_0) ##1 active_mode == MODE_0
		|=> rails == $past(reg_wdata, 2)) else $error("enable write not applied");
	sysbuck_write_a: assert property (
		(reg_wr && reg_addr == 8'h23 && active_mode == MODE_0) ##1 active_mode == MODE_0
		|=> {sysbuck_offset, sysbuck_code} == $past(wd_low, 2))
		else $error("system buck write not applied");
endmodule

`default_nettype wire

// *** test/test_mode0_rail_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_mode0_rail_config_regs;
	import mode0_rail_pkg::*;
	logic ref_clk = 1'h0, rst = 1'h1, reg_wr, reg_rd, onpin_fall = 1'h0;
	logic mode_source_pin_sel_m0 = 1'h0, mode_select_pin_a = 1'h0, mode_select_pin_b = 1'h0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v1, v2;
	logic [3:0] rewritable_nv_trim = 4'hA;
	logic [1:0] reg_mode_bits = 2'h0;
	mode_type active_mode;
	logic mode0_active, corebuck_enable, sysbuck_enable, aon_ldo_enable, sys_ldo_enable;
	logic sysbuck_offset;
	logic [4:0] sysbuck_code;
	logic [3:0] aon_ldo_code;
	logic [11:0] sysbuck_mv, aon_ldo_mv;
	logic [4:0] bc [4] = '{5'h00, 5'h18, 5'h19, 5'h1F};
	logic [3:0] lc [4] = '{4'h0, 4'h8, 4'h9, 4'hF};
	int fail_count = 0, checks_done = 0;

	always #10 ref_clk = ~ref_clk;

	mode0_rail_config_regs u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rewritable_nv_trim, .mode_source_pin_sel_m0, .mode_select_pin_a,
		.mode_select_pin_b, .reg_mode_bits, .onpin_fall, .active_mode, .mode0_active,
		.corebuck_enable, .sysbuck_enable, .aon_ldo_enable, .sys_ldo_enable, .sysbuck_code,
		.sysbuck_offset, .aon_ldo_code, .sysbuck_mv, .aon_ldo_mv);
	reg_host_model u_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// One qualified on-pin pulse
	task automatic pulse();
		@(posedge ref_clk);
		onpin_fall <= 1'h1;
		@(posedge ref_clk);
		onpin_fall <= 1'h0;
		settle();
	endtask

	// Reset image, field sweep, refusals, mode sources
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		u_host.rd(8'h23, d);
		chk(d, 8'h0C);
		u_host.rd(8'h24, d);
		chk(d, 8'h4A);
		chk(sysbuck_mv, 12'h708);
		chk(aon_ldo_mv, 12'h708);
		for (int i = 0; i < 4; i++) begin
			v1 = {i[0], 1'h0, i[1], bc[i]};
			v2 = {lc[i], 4'h1 << i};
			u_host.wr(8'h23, v1);
			u_host.wr(8'h24, v2);
			u_host.rd(8'h23, d);
			chk(d, v1);
			u_host.rd(8'h24, d);
			chk(d, v2);
			chk({corebuck_enable, sysbuck_enable, aon_ldo_enable, sys_ldo_enable}, v2[3:0]);
			chk(sysbuck_mv, 12'h5DC + (i[1] ? 12'h4B0 : 12'h0) + (i == 0 ? 12'h0 : 12'h258));
			chk(aon_ldo_mv, i == 0 ? 12'h6A4 : 12'h76C);
		end
		u_host.wr(8'h25, 8'hFF);
		u_host.rd(8'h25, d);
		chk(d, 8'h00);
		@(posedge ref_clk);
		reg_mode_bits <= 2'h1;
		settle();
		chk(active_mode, MODE_1);
		u_host.wr(8'h24, 8'h3F);
		settle();
		chk(aon_ldo_code, 4'hF);
		pulse();
		chk(active_mode, MODE_0);
		settle();
		chk(aon_ldo_code, 4'h3);
		u_host.wr(8'h23, 8'h40);
		reg_mode_bits <= 2'h2;
		settle();
		pulse();
		chk(active_mode, MODE_2);
		@(posedge ref_clk);
		mode_source_pin_sel_m0 <= 1'h1;
		mode_select_pin_a <= 1'h1;
		mode_select_pin_b <= 1'h1;
		repeat (8) @(posedge ref_clk);
		reg_mode_bits <= 2'h0;
		settle();
		chk(active_mode, MODE_3);
		results();
	end

	// Watchdog
	initial begin
		#40000;
		fail_count++;
		results();
	end
endmodule

bind mode0_rail_config_regs rail_cfg_checker u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .mode_source_pin_sel_m0, .reg_mode_bits, .onpin_fall,
	.active_mode, .mode0_active, .corebuck_enable, .sysbuck_enable, .aon_ldo_enable,
	.sys_ldo_enable, .sysbuck_code, .sysbuck_offset, .aon_ldo_code, .sysbuck_mv, .aon_ldo_mv);

`default_nettype wire
